//--- interval_timer_defs.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 16-bit interval timer, plus the behaviour summary.
 Assumes it is included by its bare name from the package file.

 //Behaviour
 //R1: One 16-bit timer, synchronous or asynchronous, interval timer or event counter.
 //R2: Count clock from bus clock, secondary oscillator, clock pin or low-power RC.
 //R3: Modes: sync internal, sync gated, sync external, async external counting.
 //R4: Selectable prescaler; counting may continue through Sleep and Idle.
 //R5: Software never writes period values zero or one.
 //R6: Enable bit 15 turns the timer on when one, off when zero.
 //R7: Stop-in-idle bit 13 halts the timer in Idle when set.
 //R8: Write-block bit 12 drops count writes while an async write pends.
 //R9: Write-pending bit 11 is one during an async count write, else zero.
 //R10: Bits 9-8 pick secondary oscillator, clock pin, low-power RC; 11 reserved.
 //R11: Gated bit 7 acts only with internal clock selected.
 //R12: Prescale bits 5-4 divide by 1, 8, 64 or 256.
 //R13: Synchronize bit 2 syncs an external clock; ignored on internal clock.
 //R14: Clock source bit 1 picks internal clock at zero, external at one.
 //R15: Unimplemented bits read zero; reset values match the defaults.
 //R16: Clear, set and invert aliases sit at plus 0x4, 0x8 and 0xC.
 //R17: Each tick increments; at period match wraps to zero and flags an event.
 //R18: Gated mode counts while gate high; flags event on gate falling edge.
 //R19: Async count writes cross to the external domain, pending until applied.
*/
`ifndef INTERVAL_TIMER_DEFS_SVH
`define INTERVAL_TIMER_DEFS_SVH

`define TMR_CONTROL_OFS 16'h8000
`define TMR_COUNT_OFS 16'h8010
`define TMR_PERIOD_OFS 16'h8020
`define TMR_IRQ_STATUS_OFS 16'h8030
`define TMR_IRQ_MASK_OFS 16'h8040

`define ALIAS_WRITE 2'h0
`define ALIAS_CLEAR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_INVERT 2'h3

`define CTL_ENABLE_BIT 15
`define CTL_STOP_IDLE_BIT 13
`define CTL_WR_BLOCK_BIT 12
`define CTL_WR_PEND_BIT 11
`define CTL_ECS_LSB 8
`define CTL_GATE_BIT 7
`define CTL_PRE_LSB 4
`define CTL_SYNC_BIT 2
`define CTL_SRC_BIT 1
// Writable bits of the control register; all others read zero except write-pending bit 11
`define CTL_WRITE_MASK 16'hb3b6

`define CONTROL_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define PERIOD_RESET 16'hffff

`define IRQ_MATCH_BIT 0
`define IRQ_GATE_BIT 1

`define PRE_DIV_1 8'h00
`define PRE_DIV_8 8'h07
`define PRE_DIV_64 8'h3f
`define PRE_DIV_256 8'hff

`endif

//--- interval_timer_pkg.sv
/*
 Types shared by the interval timer modules.
 Assumes interval_timer_defs.svh is on the include path.
*/
`include "interval_timer_defs.svh"
package interval_timer_pkg;
   typedef logic [15:0] word16_t;
   // Decoded control fields as the counting logic sees them
   typedef struct packed {
      logic enable;
      logic stop_in_idle;
      logic async_write_block;
      logic [1:0] ext_clock_select;
      logic gated_accumulate_en;
      logic [1:0] prescale_select;
      logic ext_clock_synchronize;
      logic clock_source_select;
   } timer_ctl_s;
   typedef enum logic [2:0] {
      XFER_IDLE = 3'b001,
      XFER_WAIT = 3'b010,
      XFER_DONE = 3'b100
   } xfer_state_e;
endpackage

//--- ext_clock_gen.sv
/*
 External count domain: counts on the selected external clock when the
 timer runs without synchronisation, takes count writes over a handshake.
 Assumes ext_clk is the already selected external clock; the flop-based
 request/ack pair carries count writes; period and div_max cross unsynchronised.
*/
`timescale 1ns/10ps
module ext_clock_gen (
   input wire logic ext_clk,
   input wire logic rst_n,
   input wire logic run_lvl,
   input interval_timer_pkg::word16_t period,
   input wire logic [7:0] div_max,
   input wire logic wr_req,
   input interval_timer_pkg::word16_t wr_data,
   output logic wr_ack,
   output interval_timer_pkg::word16_t count,
   output logic match_tgl
);
   import interval_timer_pkg::*;
   logic req_meta_ff, req_sync_ff, req_seen_ff;
   logic run_meta_ff, run_sync_ff;
   logic [7:0] div_ff;
   word16_t count_ff;
   logic match_tgl_ff;
   logic new_req;

   // Control levels from the bus domain pass two flops first
   always_ff @(posedge ext_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_meta_ff <= 1'b0;
         req_sync_ff <= 1'b0;
         run_meta_ff <= 1'b0;
         run_sync_ff <= 1'b0;
         req_seen_ff <= 1'b0;
      end else begin
         req_meta_ff <= wr_req;
         req_sync_ff <= req_meta_ff;
         run_meta_ff <= run_lvl;
         run_sync_ff <= run_meta_ff;
         req_seen_ff <= req_sync_ff;
      end
   end
   assign new_req = req_sync_ff & ~req_seen_ff;

   // Async counting; a write applies the held data, which is stable while req is up
   always_ff @(posedge ext_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= `COUNT_RESET;
         div_ff <= 8'h00;
         match_tgl_ff <= 1'b0;
      end else if (new_req) begin
         count_ff <= wr_data; // R19
         div_ff <= 8'h00;
      end else if (run_sync_ff) begin
         if (div_ff >= div_max) begin
            div_ff <= 8'h00;
            if (count_ff == period) begin
               count_ff <= 16'h0000; // R17
               match_tgl_ff <= ~match_tgl_ff;
            end else begin
               count_ff <= count_ff + 16'h0001;
            end
         end else begin
            div_ff <= div_ff + 8'h01;
         end
      end
   end
   assign wr_ack = req_seen_ff; // R19
   assign count = count_ff;
   assign match_tgl = match_tgl_ff;
endmodule // ext_clock_gen

//--- interval_timer.sv
/*
 16-bit interval timer and event counter with an AXI4-Lite register slave,
 clear/set/invert aliases, prescaler, gating and an async count domain.
 Assumes external clock, gate and idle inputs are asynchronous pins; the
 async ack, match toggle and count are sampled through synchronisers.
*/
`timescale 1ns/10ps
module interval_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic secondary_oscillator,
   input wire logic timer_ext_clock_pin,
   input wire logic low_power_rc_osc,
   input wire logic gate_in,
   input wire logic idle_mode,
   input wire logic sleep_mode,
   output logic irq
);
   import interval_timer_pkg::*;

   word16_t control_ff, count_ff, period_ff;
   logic [1:0] irq_status_ff, irq_mask_ff;
   timer_ctl_s ctl;
   logic [15:0] aw_ff;
   logic aw_full_ff, w_full_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic wr_go, wr_hit_ok;
   logic [15:0] rd_val;
   logic rd_hit_ok;
   logic ext_raw;
   logic ext_m_ff, ext_s_ff, ext_d_ff;
   logic gate_m_ff, gate_s_ff, gate_d_ff;
   logic idle_m_ff, idle_s_ff, sleep_m_ff, sleep_s_ff;
   logic [7:0] div_max, pre_ff;
   logic async_mode, sync_tick, src_edge, running;
   logic match_evt, gate_fall;
   xfer_state_e xfer_ff;
   logic xfer_req_ff;
   word16_t xfer_data_ff;
   logic ack_m_ff, ack_s_ff;
   logic [15:0] acnt_m_ff, acnt_s_ff;
   logic mt_m_ff, mt_s_ff, mt_d_ff;
   word16_t async_count;
   logic async_match_tgl, async_ack, count_wr, count_wr_ok;
   logic async_ack_raw;
   word16_t async_count_raw;
   word16_t count_new;
   logic [1:0] wr_alias, irq_set;
   logic [15:0] wr_reg, wr_word;

   // Register address to base offset: the alias lives in bits 3:2
   function automatic logic [15:0] reg_base(input logic [15:0] a);
      reg_base = {a[15:4], 4'h0};
   endfunction

   // Apply a write, clear, set or invert to a register image
   function automatic logic [15:0] alias_op(input logic [15:0] cur,
                                            input logic [15:0] d,
                                            input logic [1:0] op);
      unique case (op)
         `ALIAS_WRITE: alias_op = d;
         `ALIAS_CLEAR: alias_op = cur & ~d;
         `ALIAS_SET: alias_op = cur | d;
         `ALIAS_INVERT: alias_op = cur ^ d;
      endcase
   endfunction

   function automatic logic known_reg(input logic [15:0] b);
      known_reg = (b == `TMR_CONTROL_OFS) || (b == `TMR_COUNT_OFS) ||
                  (b == `TMR_PERIOD_OFS) || (b == `TMR_IRQ_STATUS_OFS) ||
                  (b == `TMR_IRQ_MASK_OFS);
   endfunction

   assign ctl.enable = control_ff[`CTL_ENABLE_BIT];
   assign ctl.stop_in_idle = control_ff[`CTL_STOP_IDLE_BIT];
   assign ctl.async_write_block = control_ff[`CTL_WR_BLOCK_BIT];
   assign ctl.ext_clock_select = control_ff[`CTL_ECS_LSB +: 2];
   assign ctl.gated_accumulate_en = control_ff[`CTL_GATE_BIT];
   assign ctl.prescale_select = control_ff[`CTL_PRE_LSB +: 2];
   assign ctl.ext_clock_synchronize = control_ff[`CTL_SYNC_BIT];
   assign ctl.clock_source_select = control_ff[`CTL_SRC_BIT];

   // Write channel: address and data taken independently, any order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_ff <= 1'b0;
         w_full_ff <= 1'b0;
         aw_ff <= 16'h0000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_ff <= 1'b1;
            aw_ff <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_full_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (wr_go) begin
            w_full_ff <= 1'b0;
         end
      end
   end
   assign s_axi_awready = ~aw_full_ff & ~s_axi_bvalid;
   assign s_axi_wready = ~w_full_ff & ~s_axi_bvalid;
   assign wr_go = aw_full_ff & w_full_ff & ~s_axi_bvalid;
   assign wr_reg = reg_base(aw_ff);
   assign wr_alias = aw_ff[3:2];
   assign wr_hit_ok = known_reg(wr_reg) && (aw_ff[1:0] == 2'b00);
   // Only the low 16 bits exist; a byte lane with its strobe low contributes zeros
   assign wr_word = {wstrb_ff[1] ? wdata_ff[15:8] : 8'h00,
                     wstrb_ff[0] ? wdata_ff[7:0] : 8'h00};

   // Write response, SLVERR for unmapped addresses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register; write-pending bit is status and never stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         control_ff <= `CONTROL_RESET; // R15
      end else if (wr_go && wr_hit_ok && wr_reg == `TMR_CONTROL_OFS &&
                   wstrb_ff[1:0] != 2'b00) begin
         control_ff <= alias_op(control_ff, wr_word, wr_alias) & `CTL_WRITE_MASK; // R16
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         period_ff <= `PERIOD_RESET; // R15
      end else if (wr_go && wr_hit_ok && wr_reg == `TMR_PERIOD_OFS &&
                   wstrb_ff[1:0] != 2'b00) begin
         period_ff <= alias_op(period_ff, wr_word, wr_alias); // R16
      end
   end

   // External source choice; code 11 is reserved and gives no clock
   always_comb begin
      unique case (ctl.ext_clock_select) // R10
         2'b00: ext_raw = secondary_oscillator;
         2'b01: ext_raw = timer_ext_clock_pin;
         2'b10: ext_raw = low_power_rc_osc;
         2'b11: ext_raw = 1'b0;
      endcase
   end

   // Pin inputs through two flops, then edge detection on the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ext_m_ff, ext_s_ff, ext_d_ff} <= 3'b000;
         {gate_m_ff, gate_s_ff, gate_d_ff} <= 3'b000;
         {idle_m_ff, idle_s_ff, sleep_m_ff, sleep_s_ff} <= 4'h0;
      end else begin
         {ext_m_ff, ext_s_ff, ext_d_ff} <= {ext_raw, ext_m_ff, ext_s_ff};
         {gate_m_ff, gate_s_ff, gate_d_ff} <= {gate_in, gate_m_ff, gate_s_ff};
         {idle_m_ff, idle_s_ff} <= {idle_mode, idle_m_ff};
         {sleep_m_ff, sleep_s_ff} <= {sleep_mode, sleep_m_ff};
      end
   end

   always_comb begin
      unique case (ctl.prescale_select) // R12
         2'b00: div_max = `PRE_DIV_1;
         2'b01: div_max = `PRE_DIV_8;
         2'b10: div_max = `PRE_DIV_64;
         2'b11: div_max = `PRE_DIV_256;
      endcase
   end

   // Async only with external clock and sync off; sync bit ignored on internal
   assign async_mode = ctl.clock_source_select & ~ctl.ext_clock_synchronize; // R13 R3
   // Bus clock stops in Sleep, so only the async path keeps counting there
   assign running = ctl.enable & ~(ctl.stop_in_idle & idle_s_ff) &
                    ~(sleep_s_ff & ~async_mode); // R6 R7 R4
   // Tick source: bus clock, gated bus clock, or synced external rising edge
   assign src_edge = ctl.clock_source_select ? (ext_s_ff & ~ext_d_ff) : // R14 R2
                     (ctl.gated_accumulate_en ? gate_s_ff : 1'b1); // R11 R18

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_ff <= 8'h00;
      end else if (!running || async_mode || count_wr_ok) begin
         pre_ff <= 8'h00;
      end else if (src_edge) begin
         pre_ff <= (pre_ff >= div_max) ? 8'h00 : pre_ff + 8'h01; // R12
      end
   end
   assign sync_tick = running & ~async_mode & src_edge & (pre_ff >= div_max);

   // Count writes, any alias, resolved against the visible count
   assign count_wr = wr_go && wr_hit_ok && wr_reg == `TMR_COUNT_OFS &&
                     wstrb_ff[1:0] != 2'b00;
   assign count_new = alias_op(async_mode ? async_count : count_ff, wr_word, wr_alias);
   assign count_wr_ok = count_wr &&
                        !(async_mode && ctl.async_write_block && xfer_ff != XFER_IDLE); // R8

   // Synchronous counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff <= `COUNT_RESET;
      end else if (count_wr_ok && !async_mode) begin
         count_ff <= count_new;
      end else if (sync_tick) begin
         count_ff <= (count_ff == period_ff) ? 16'h0000 : count_ff + 16'h0001; // R17 R1
      end
   end

   // Async write handshake; a write arriving while one is pending is lost, held data kept
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xfer_ff <= XFER_IDLE;
         xfer_req_ff <= 1'b0;
         xfer_data_ff <= 16'h0000;
      end else begin
         unique case (xfer_ff)
            XFER_IDLE: begin
               if (count_wr_ok && async_mode) begin
                  xfer_data_ff <= count_new; // R19
                  xfer_req_ff <= 1'b1;
                  xfer_ff <= XFER_WAIT;
               end
            end
            XFER_WAIT: begin
               if (async_ack) begin
                  xfer_req_ff <= 1'b0;
                  xfer_ff <= XFER_DONE;
               end
            end
            XFER_DONE: begin
               if (!async_ack) begin
                  xfer_ff <= XFER_IDLE;
               end
            end
            default: xfer_ff <= XFER_IDLE;
         endcase
      end
   end

   ext_clock_gen u_ext (
      .ext_clk(ext_raw),
      .rst_n(rst_n),
      .run_lvl(ctl.enable & async_mode & ~(ctl.stop_in_idle & idle_s_ff)),
      .period(period_ff),
      .div_max(div_max),
      .wr_req(xfer_req_ff),
      .wr_data(xfer_data_ff),
      .wr_ack(async_ack_raw),
      .count(async_count_raw),
      .match_tgl(async_match_tgl)
   );

   // Async results come back through two flops; count may be a transition
   // value on one read, a known limitation of sampling a free bus
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ack_m_ff, ack_s_ff} <= 2'b00;
         {mt_m_ff, mt_s_ff, mt_d_ff} <= 3'b000;
         acnt_m_ff <= 16'h0000;
         acnt_s_ff <= 16'h0000;
      end else begin
         {ack_m_ff, ack_s_ff} <= {async_ack_raw, ack_m_ff};
         {mt_m_ff, mt_s_ff, mt_d_ff} <= {async_match_tgl, mt_m_ff, mt_s_ff};
         acnt_m_ff <= async_count_raw;
         acnt_s_ff <= acnt_m_ff;
      end
   end
   assign async_ack = ack_s_ff;
   assign async_count = acnt_s_ff;

   // Events: period match either domain, gate falling edge in gated mode
   assign match_evt = (sync_tick && count_ff == period_ff) ||
                      (async_mode && (mt_s_ff ^ mt_d_ff)); // R17
   assign gate_fall = running && !ctl.clock_source_select && ctl.gated_accumulate_en &&
                      gate_d_ff && !gate_s_ff; // R18
   assign irq_set = {gate_fall, match_evt};

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_ff <= 2'b00;
         irq_mask_ff <= 2'b00;
      end else begin
         if (wr_go && wr_hit_ok && wr_reg == `TMR_IRQ_STATUS_OFS && wstrb_ff[0]) begin
            irq_status_ff <= (irq_status_ff & ~wr_word[1:0]) | irq_set;
         end else begin
            irq_status_ff <= irq_status_ff | irq_set;
         end
         if (wr_go && wr_hit_ok && wr_reg == `TMR_IRQ_MASK_OFS && wstrb_ff[0]) begin
            irq_mask_ff <= 2'(alias_op({14'h0000, irq_mask_ff}, wr_word, wr_alias));
         end
      end
   end
   assign irq = |(irq_status_ff & irq_mask_ff);

   // Read data; any alias address reads the register itself
   always_comb begin
      rd_hit_ok = known_reg(reg_base(s_axi_araddr)) && (s_axi_araddr[1:0] == 2'b00);
      unique case (reg_base(s_axi_araddr))
         `TMR_CONTROL_OFS: rd_val = control_ff |
                             (16'(async_mode && xfer_ff != XFER_IDLE) << `CTL_WR_PEND_BIT); // R9
         `TMR_COUNT_OFS: rd_val = async_mode ? async_count : count_ff;
         `TMR_PERIOD_OFS: rd_val = period_ff;
         `TMR_IRQ_STATUS_OFS: rd_val = {14'h0000, irq_status_ff};
         `TMR_IRQ_MASK_OFS: rd_val = {14'h0000, irq_mask_ff};
         default: rd_val = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_hit_ok ? rd_val : 16'h0000}; // R15
         s_axi_rresp <= rd_hit_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = ~s_axi_rvalid;
endmodule // interval_timer

//--- interval_timer_props.sv
/*
 Port assertions for the interval timer: bus handshakes, read data, irq.
 Assumes one clk domain with rst_n asynchronous and active low.
*/
`timescale 1ns/10ps
module interval_timer_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq
);
   // Everything samples on clk and stands down during reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_irq_reset;
      $rose(rst_n) |-> !irq;
   endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("irq high after reset");
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read response late");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
   property p_upper_zero;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper half not zero");
   // Anything outside the five registers and their aliases is refused
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr[15:8] != 8'h80 ||
         s_axi_araddr[7:4] > 4'h4 || s_axi_araddr[1:0] != 2'h0)
         |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
   property p_ctl_zero;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 16'h8000
         |=> (s_axi_rdata[15:0] & 16'h4449) == 16'h0;
   endproperty
   a_ctl_zero: assert property (p_ctl_zero) else $error("unused control bit set");
endmodule // interval_timer_props

bind interval_timer interval_timer_props u_props (.*);

//--- sync_async_16bit_interval_timer_tb_top.sv
/*
 Self-checking bench for the interval timer over AXI4-Lite.
 Assumes a 20 MHz clk; external clocks are made here at clk/8.
*/
`timescale 1ns/10ps
module sync_async_16bit_interval_timer_tb_top;
   import interval_timer_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] s_axi_awaddr = 16'h0;
   logic [15:0] s_axi_araddr = 16'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [31:0] s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
   logic secondary_oscillator = 1'b0;
   logic timer_ext_clock_pin = 1'b0;
   logic low_power_rc_osc = 1'b0;
   logic gate_in = 1'b0;
   logic idle_mode = 1'b0;
   logic sleep_mode = 1'b0;
   logic [2:0] ext_run = 3'h0;
   logic [31:0] rd_val;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;

   interval_timer u_dut (.*);

   always #25 clk = ~clk;

   // External clocks toggle every 4 rising clk edges; a hang ends the run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc[1:0] == 2'h0) begin
         secondary_oscillator <= secondary_oscillator ^ ext_run[0];
         timer_ext_clock_pin <= timer_ext_clock_pin ^ ext_run[1];
         low_power_rc_osc <= low_power_rc_osc ^ ext_run[2];
      end
      if (cyc == 20000) begin
         errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Address and data go out together; bready stays up until the response
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, 2'h0);
   endtask

   // rready comes late on purpose so the slave must hold its answer
   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat (2) @(posedge clk);
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_rvalid);
      rd_val = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rc(input logic [15:0] a, input logic [31:0] e);
      rd(a);
      chk(rd_val, e);
   endtask

   task automatic t_regs();
      rc(16'h8000, 32'h0);
      rc(16'h8010, 32'h0);
      rc(16'h8020, 32'hffff);
      rd(16'h8050);
      chk(rd_resp, 2'h2);
      wr(16'h8000, 32'hffff_ffff);
      rc(16'h8000, 32'hb3b6);
      wr(16'h8004, 32'hffff);
      rc(16'h8000, 32'h0);
      wr(16'h8024, 32'h00f0);
      rc(16'h8020, 32'hff0f);
      wr(16'h802c, 32'h0f0f);
      rc(16'h8020, 32'hf000);
      wr(16'h8028, 32'hffff_0003);
      rc(16'h8020, 32'hf003);
   endtask

   task automatic t_match();
      wr(16'h8020, 32'h3);
      wr(16'h8040, 32'h1);
      wr(16'h8000, 32'h8000);
      repeat (20) @(posedge clk);
      chk(irq, 1'b1);
      rd(16'h8010);
      chk(rd_val <= 32'h3, 1'b1);
      wr(16'h8000, 32'h0);
      rc(16'h8030, 32'h1);
      wr(16'h8040, 32'h0);
      chk(irq, 1'b0);
      wr(16'h8030, 32'h1);
      rc(16'h8030, 32'h0);
   endtask

   // 1024 clk of counting must come out near 1024 over the divisor
   task automatic t_prescale();
      int n;
      wr(16'h8020, 32'hffff);
      for (int p = 0; p < 4; p++) begin
         wr(16'h8010, 32'h0);
         wr(16'h8000, 32'h8000 | (p << 4));
         repeat (1024) @(posedge clk);
         wr(16'h8000, 32'h0);
         rd(16'h8010);
         n = 1024 >> ((p == 3) ? 8 : 3 * p);
         chk(rd_val + 1 >= n && rd_val <= n + 8, 1'b1);
      end
   endtask

   task automatic t_idle_gate();
      wr(16'h8000, 32'ha000);
      idle_mode <= 1'b1;
      wr(16'h8010, 32'h5);
      repeat (50) @(posedge clk);
      rc(16'h8010, 32'h5);
      wr(16'h8000, 32'h8000);
      repeat (50) @(posedge clk);
      rd(16'h8010);
      chk(rd_val > 32'h5, 1'b1);
      idle_mode <= 1'b0;
      wr(16'h8000, 32'h8080);
      wr(16'h8010, 32'h0);
      repeat (20) @(posedge clk);
      gate_in <= 1'b1;
      repeat (30) @(posedge clk);
      gate_in <= 1'b0;
      repeat (10) @(posedge clk);
      wr(16'h8000, 32'h0);
      rd(16'h8010);
      chk(rd_val >= 32'h1b && rd_val <= 32'h21, 1'b1);
      rc(16'h8030, 32'h2);
      wr(16'h8030, 32'h2);
   endtask

   // Only the selected source runs, all three for reserved code 11; gate bit set with gate low must not matter
   task automatic t_ext();
      for (int s = 0; s < 4; s++) begin
         wr(16'h8010, 32'h0);
         wr(16'h8000, 32'h8086 | (s << 8));
         ext_run <= (s == 3) ? 3'h7 : 3'(1 << s);
         repeat (200) @(posedge clk);
         ext_run <= 3'h0;
         wr(16'h8000, 32'h0);
         rd(16'h8010);
         chk((s == 3) ? rd_val == 0 : rd_val >= 32'h14 && rd_val <= 32'h1b, 1'b1);
      end
   endtask

   // Async write stalls with the pin clock still; a second write is dropped
   task automatic t_async();
      idle_mode <= 1'b1;
      wr(16'h8000, 32'h9102);
      wr(16'h8010, 32'h100);
      rd(16'h8000);
      chk(rd_val[11], 1'b1);
      wr(16'h8010, 32'h200);
      wr(16'h8000, 32'hb102);
      ext_run <= 3'h2;
      repeat (100) @(posedge clk);
      rc(16'h8000, 32'hb102);
      rc(16'h8010, 32'h100);
      sleep_mode <= 1'b1;
      wr(16'h8000, 32'h9102);
      repeat (40) @(posedge clk);
      ext_run <= 3'h0;
      rd(16'h8010);
      chk(rd_val > 32'h100, 1'b1);
      idle_mode <= 1'b0;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_match();
      t_prescale();
      t_idle_gate();
      t_ext();
      t_async();
      test_done();
   end
endmodule // sync_async_16bit_interval_timer_tb_top
